// ### rtl/xpr_ctrl.sv
// Host controller driving the crosspoint route latch pins
// Notes on behaviour
// - Load: clear high, readback low, select low, commit high, write strobe low.
// - Host drives the output index to choose which code is read back.
// - Host uses only the valid control combinations.
// - Fan-out to several outputs takes one write per output.
`timescale 1ns/10ps
`include "xpr_map.svh"
module xpr_ctrl
   import xpr_pkg::*;
#(
   parameter int CODE_W = 4
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic matrix_clear_n,
   output logic readback_sel,
   output logic chip_sel_n,
   output logic write_strobe_n,
   output logic commit_strobe_n,
   output logic [1:0] output_index,
   output logic [CODE_W-1:0] route_code_out,
   output logic route_code_oe,
   input wire logic [CODE_W-1:0] route_code_in
);
   localparam int SETUP_CYC = (`XPR_SETUP_NS + `XPR_CLK_NS - 1) / `XPR_CLK_NS;
   localparam int PULSE_CYC = (`XPR_PULSE_NS + `XPR_CLK_NS - 1) / `XPR_CLK_NS;
   localparam int OUT_CYC = (`XPR_OUTPUT_NS + `XPR_CLK_NS - 1) / `XPR_CLK_NS;
   initial
   begin
      if (CODE_W != 4)
      begin
         $error("xpr_ctrl needs a 4-bit route code");
      end
   end
   xpr_state_t state;
   logic [3:0] cnt;
   logic busy;
   logic [CODE_W-1:0] readback;
   logic [CODE_W-1:0] shadow_code;
   logic [1:0] shadow_idx;
   logic [3:0] route_ok;
   logic [CODE_W-1:0] pend_code;
   logic [1:0] pend_idx;
   logic shadow_wr;
   assign busy = (state != xpr_idle);
   assign shadow_wr = (state == xpr_wr_hold) && (cnt == '0);
   // Commands arriving while busy are dropped; software polls status first
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= xpr_idle;
         cnt <= '0;
         pend_code <= '0;
         pend_idx <= '0;
      end
      else if (state == xpr_idle)
      begin
         if (wr && addr == `XPR_REG_ROUTE)
         begin
            pend_code <= wdata[CODE_W-1:0];
            pend_idx <= wdata[`XPR_ROUTE_IDX_LSB +: 2];
            state <= xpr_wr_setup;
            cnt <= 4'(SETUP_CYC - 1);
         end
         else if (wr && addr == `XPR_REG_CTRL && wdata[`XPR_CTRL_COMMIT])
         begin
            state <= xpr_cm_pulse;
            cnt <= 4'(PULSE_CYC - 1);
         end
         else if (wr && addr == `XPR_REG_CTRL && wdata[`XPR_CTRL_READ])
         begin
            pend_idx <= wdata[`XPR_ROUTE_IDX_LSB +: 2];
            state <= xpr_rd_setup;
            cnt <= 4'(SETUP_CYC - 1);
         end
         else if (wr && addr == `XPR_REG_CTRL && wdata[`XPR_CTRL_CLEAR])
         begin
            state <= xpr_cl_pulse;
            cnt <= 4'(PULSE_CYC - 1);
         end
      end
      else if (cnt != '0)
      begin
         cnt <= cnt - 4'h1;
      end
      else
      begin
         unique case (state)
            xpr_wr_setup:
            begin
               state <= xpr_wr_pulse;
               cnt <= 4'(PULSE_CYC - 1);
            end
            xpr_wr_pulse:
            begin
               state <= xpr_wr_hold;
               cnt <= 4'(SETUP_CYC - 1);
            end
            xpr_rd_setup:
            begin
               state <= xpr_rd_wait;
               cnt <= 4'(OUT_CYC - 1);
            end
            xpr_wr_hold, xpr_cm_pulse, xpr_rd_wait, xpr_cl_pulse, xpr_idle:
            begin
               state <= xpr_idle;
            end
         endcase
      end
   end
   // Pins come straight from state flops so only valid combinations appear
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         matrix_clear_n <= 1'b1;
         readback_sel <= 1'b0;
         chip_sel_n <= 1'b1;
         write_strobe_n <= 1'b1;
         commit_strobe_n <= 1'b1;
         output_index <= '0;
         route_code_out <= '0;
         route_code_oe <= 1'b1;
      end
      else
      begin
         output_index <= pend_idx;
         // Disabled routes send the low bits as zero; the device ignores them
         route_code_out <= pend_code[`XPR_ROUTE_EN_BIT] ? pend_code : 4'h0;
         // Select stays high during commit so the active set never goes transparent
         chip_sel_n <= !(state inside {xpr_wr_setup, xpr_wr_pulse, xpr_wr_hold,
            xpr_rd_setup, xpr_rd_wait});
         write_strobe_n <= (state != xpr_wr_pulse);
         commit_strobe_n <= (state != xpr_cm_pulse);
         matrix_clear_n <= (state != xpr_cl_pulse);
         readback_sel <= (state inside {xpr_rd_setup, xpr_rd_wait});
         route_code_oe <= !(state inside {xpr_rd_setup, xpr_rd_wait});
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         readback <= '0;
      end
      else if (state == xpr_rd_wait && cnt == '0)
      begin
         readback <= route_code_in;
      end
   end
   // Shadow tracks host-written codes; outputs count as routed in route_ok once the write ends, before any commit
   xpr_shadow #(.OUTPUTS(4), .CODE_W(CODE_W)) u_shadow (
      .clk(clk),
      .reset(reset),
      .wr_en(shadow_wr),
      .wr_idx(pend_idx),
      .wr_code(pend_code),
      .rd_idx(pend_idx),
      .rd_code(shadow_code)
   );
   assign shadow_idx = pend_idx;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         route_ok <= '0;
      end
      else if (state == xpr_cl_pulse)
      begin
         route_ok <= '0;
      end
      else if (shadow_wr)
      begin
         route_ok[shadow_idx] <= pend_code[`XPR_ROUTE_EN_BIT];
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rdata <= '0;
      end
      else if (rd)
      begin
         unique case (addr)
            `XPR_REG_ROUTE: rdata <= {4'h0, shadow_code};
            `XPR_REG_CTRL: rdata <= {6'h00, pend_idx};
            `XPR_REG_STATUS: rdata <= {3'h0, busy, route_ok};
            `XPR_REG_READBACK: rdata <= {4'h0, readback};
         endcase
      end
      else
      begin
         rdata <= '0;
      end
   end
   write_low_a: assert property (@(posedge clk) disable iff (reset)
      !write_strobe_n |-> !chip_sel_n && commit_strobe_n && !readback_sel)
      else $error("write strobe outside a valid load");
   write_width_a: assert property (@(posedge clk) disable iff (reset)
      $fell(write_strobe_n) |-> !write_strobe_n [*5])
      else $error("write strobe too short");
   commit_alone_a: assert property (@(posedge clk) disable iff (reset)
      !commit_strobe_n |-> write_strobe_n && chip_sel_n && matrix_clear_n)
      else $error("commit strobe with other strobes");
   readback_pins_a: assert property (@(posedge clk) disable iff (reset)
      readback_sel |-> !route_code_oe && write_strobe_n && commit_strobe_n)
      else $error("code pins driven during readback");
   release_a: assert property (@(posedge clk) disable iff (reset)
      $fell(readback_sel) |-> route_code_oe)
      else $error("code pins not retaken");
   clear_only_a: assert property (@(posedge clk) disable iff (reset)
      !matrix_clear_n |-> write_strobe_n && commit_strobe_n && chip_sel_n)
      else $error("clear with strobe active");
   disabled_code_a: assert property (@(posedge clk) disable iff (reset)
      !write_strobe_n && !route_code_out[`XPR_ROUTE_EN_BIT] |-> route_code_out == 4'h0)
      else $error("disabled route sent with input bits");
   index_hold_a: assert property (@(posedge clk) disable iff (reset)
      !write_strobe_n |-> $stable(output_index))
      else $error("index moved during load");
   valid_combo_a: assert property (@(posedge clk) disable iff (reset)
      {matrix_clear_n, readback_sel, chip_sel_n, write_strobe_n, commit_strobe_n}
      inside {5'h17, 5'h13, 5'h11, 5'h16, 5'h1b, 5'h07})
      else $error("invalid control combination");
   load_c: cover property (@(posedge clk) $rose(write_strobe_n));
   commit_c: cover property (@(posedge clk) $rose(commit_strobe_n));
   read_c: cover property (@(posedge clk) $fell(readback_sel));
   clear_c: cover property (@(posedge clk) $rose(matrix_clear_n));
endmodule : xpr_ctrl

// ### rtl/xpr_map.svh
// Constants for the crosspoint route latch controller
`ifndef XPR_MAP_SVH
`define XPR_MAP_SVH
`define XPR_REG_ROUTE 2'h0
`define XPR_REG_CTRL 2'h1
`define XPR_REG_STATUS 2'h2
`define XPR_REG_READBACK 2'h3
`define XPR_CTRL_COMMIT 0
`define XPR_CTRL_READ 1
`define XPR_CTRL_CLEAR 2
`define XPR_ROUTE_EN_BIT 3
`define XPR_ROUTE_IDX_LSB 4
`define XPR_SETUP_NS 50
`define XPR_PULSE_NS 100
`define XPR_OUTPUT_NS 200
`define XPR_CLK_NS 20
`endif

// ### rtl/xpr_pkg.sv
// Types for the crosspoint route latch controller
package xpr_pkg;
   typedef enum logic [2:0] {xpr_idle, xpr_wr_setup, xpr_wr_pulse, xpr_wr_hold,
      xpr_cm_pulse, xpr_rd_setup, xpr_rd_wait, xpr_cl_pulse} xpr_state_t;
endpackage : xpr_pkg

// ### rtl/xpr_shadow.sv
// Shadow copy of the four route codes last written by the host
`timescale 1ns/10ps
`include "xpr_map.svh"
module xpr_shadow
   import xpr_pkg::*;
#(
   parameter int OUTPUTS = 4,
   parameter int CODE_W = 4
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [1:0] wr_idx,
   input wire logic [CODE_W-1:0] wr_code,
   input wire logic [1:0] rd_idx,
   output logic [CODE_W-1:0] rd_code
);
   logic [CODE_W-1:0] mem [OUTPUTS];
   initial
   begin
      if (OUTPUTS != 4 || CODE_W != 4)
      begin
         $error("xpr_shadow serves four 4-bit codes only");
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < OUTPUTS; i++)
         begin
            mem[i] <= '0;
         end
      end
      else if (wr_en)
      begin
         mem[wr_idx] <= wr_code;
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rd_code <= '0;
      end
      else
      begin
         rd_code <= mem[rd_idx];
      end
   end
endmodule : xpr_shadow

// ### tb/xpr_ctrl_tb.sv
// Self-checking bench for the crosspoint route latch controller
`timescale 1ns/10ps
`include "xpr_map.svh"
module xpr_ctrl_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic chk = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] rdata;
   logic [7:0] last_rd;
   logic clear_n, rb_sel, cs_n, wr_n, cm_n, oe, dev_drv;
   logic [1:0] idx;
   logic [3:0] code_out, dev_code, pins, dis;
   logic [3:0] last_pins = 4'h0;
   logic [7:0] exp_q[$];
   logic [3:0] stage_e[4];
   logic [3:0] act_e[4];
   int fails = 0;
   int n_checks = 0;
   integer seed = 32'hbff4_9c1c;
   xpr_ctrl #(.CODE_W(4)) dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .matrix_clear_n(clear_n), .readback_sel(rb_sel),
      .chip_sel_n(cs_n), .write_strobe_n(wr_n), .commit_strobe_n(cm_n),
      .output_index(idx), .route_code_out(code_out), .route_code_oe(oe),
      .route_code_in(pins));
   xpr_dev_model dev (.clear_n(clear_n), .readback_sel(rb_sel), .chip_sel_n(cs_n),
      .write_strobe_n(wr_n), .commit_strobe_n(cm_n), .output_index(idx),
      .code_in(pins), .code_out(dev_code), .code_drv(dev_drv), .buffer_disable_out(dis));
   always #10 clk = ~clk;
   // Undriven pins toggle so a stale value cannot pass for read data
   always @* pins = oe ? code_out : (dev_drv ? dev_code : ~last_pins);
   always @(posedge clk) last_pins <= pins;
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [1:0] a, input logic c, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      chk <= c;
      if (c)
         exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
      #1 last_rd = rdata;
   endtask : bus_rd
   task automatic wait_idle();
      for (int n = 0; n < 60; n++)
      begin
         bus_rd(`XPR_REG_STATUS, 1'b0, 8'h00);
         if (last_rd[4] === 1'b0)
            return;
      end
      check("busy", 8'h00, 8'h10);
   endtask : wait_idle
   task automatic commit_and_check();
      bus_wr(`XPR_REG_CTRL, 8'h01);
      wait_idle();
      for (int n = 0; n < 4; n++)
         act_e[n] = stage_e[n];
      #1 check("dis", {4'h0, act_e[3][3], act_e[2][3], act_e[1][3], act_e[0][3]}, dis);
   endtask : commit_and_check
   always @(posedge clk)
   begin
      rd_d <= rd && chk;
      if (rd_d)
         check("rdata", exp_q.pop_front(), rdata);
      if (rb_sel === 1'b1 && oe !== 1'b0)
         check("oe", 8'h00, 8'h01);
   end
   initial
   begin
      #200000;
      fails++;
      tally_and_finish();
   end
   initial
   begin
      logic [3:0] c;
      repeat (5) @(posedge clk);
      check("rst", 8'h2f, {2'b00, clear_n, rb_sel, cs_n, wr_n, cm_n, oe});
      reset <= 1'b0;
      for (int r = 0; r < 8; r++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            c = {1'b1, r[2:0]};
            if (r[0] && i == r[2:1])
               c = 4'($random(seed));
            bus_wr(`XPR_REG_ROUTE, {2'b00, i[1:0], c});
            wait_idle();
            stage_e[i] = c[3] ? c : 4'h0;
            bus_rd(`XPR_REG_ROUTE, 1'b1, {4'h0, c});
         end
         bus_rd(`XPR_REG_STATUS, 1'b1,
            {4'h0, stage_e[3][3], stage_e[2][3], stage_e[1][3], stage_e[0][3]});
         if (r > 0)
            check("held", {4'h0, act_e[3][3], act_e[2][3], act_e[1][3], act_e[0][3]}, dis);
         commit_and_check();
         for (int i = 0; i < 4; i++)
         begin
            bus_wr(`XPR_REG_CTRL, {2'b00, i[1:0], 4'h2});
            wait_idle();
            bus_rd(`XPR_REG_READBACK, 1'b1, {4'h0, act_e[i]});
         end
         bus_rd(`XPR_REG_CTRL, 1'b1, 8'h03);
      end
      bus_wr(`XPR_REG_CTRL, 8'h04);
      for (int k = 0; k < 20 && clear_n !== 1'b0; k++)
         @(posedge clk);
      #1 check("clr dis", 8'h00, {4'h0, dis});
      wait_idle();
      bus_rd(`XPR_REG_STATUS, 1'b1, 8'h00);
      bus_wr(`XPR_REG_CTRL, 8'h02);
      wait_idle();
      bus_rd(`XPR_REG_READBACK, 1'b1, 8'h00);
      // Second write lands while busy and must be dropped
      bus_wr(`XPR_REG_ROUTE, 8'h08);
      bus_wr(`XPR_REG_ROUTE, 8'h11);
      wait_idle();
      stage_e[0] = 4'h8;
      commit_and_check();
      tally_and_finish();
   end
endmodule : xpr_ctrl_tb

// ### tb/xpr_dev_model.sv
// Behavioural model of the crosspoint route latch device
`timescale 1ns/10ps
module xpr_dev_model
(
   input wire logic clear_n,
   input wire logic readback_sel,
   input wire logic chip_sel_n,
   input wire logic write_strobe_n,
   input wire logic commit_strobe_n,
   input wire logic [1:0] output_index,
   input wire logic [3:0] code_in,
   output logic [3:0] code_out,
   output logic code_drv,
   output logic [3:0] buffer_disable_out
);
   logic [15:0] stage = 16'h0000;
   logic [15:0] active = 16'h0000;
   always @*
   begin
      if (clear_n && !readback_sel && !chip_sel_n && !write_strobe_n)
         stage[output_index*4 +: 4] = code_in[3] ? code_in : 4'h0;
   end
   logic commit_prev = 1'b1;
   // One process owns the active set so the copy edge and clear cannot race
   // Clear opens the switches only; staging is left alone
   always @(clear_n, commit_strobe_n, chip_sel_n, write_strobe_n, stage)
   begin
      if (!clear_n)
         active = 16'h0000;
      else if (!commit_strobe_n && ((commit_prev && write_strobe_n) || !chip_sel_n))
         active = stage;
      commit_prev = commit_strobe_n;
   end
   assign code_drv = clear_n && readback_sel && !chip_sel_n && write_strobe_n
      && commit_strobe_n;
   assign code_out = active[output_index*4 +: 4];
   assign buffer_disable_out = {active[15], active[11], active[7], active[3]}
      & {4{clear_n}};
endmodule : xpr_dev_model
